// ==== ifb_arb_if.sv ====
// pending requests and their priorities handed to the level picker
`timescale 1ns/10ps
`default_nettype none
interface ifb_arb_if #(
    parameter int unsigned N = 67
);
    logic [N-1:0]                   pend;
    logic [N-1:0][ifb_pkg::PW-1:0]  prio;
    logic [ifb_pkg::PW-1:0]         level;
    logic                           any;

    modport src (output pend, output prio, input level, input any);
    modport arb (input pend, input prio, output level, output any);
endinterface
`default_nettype wire

// ==== ifb_bank.sv ====
// interrupt flag and enable register bank with request gating
//
// Contract
// - the fourth flag register holds the checksum generator flag at bit 3, read and write.
// - it holds the second serial error flag at bit 2 and the first at bit 1.
// - bits 15 to 4 and bit 0 of the fourth flag register always read zero.
// - an enable bit at 1 passes its source's request and at 0 blocks it.
// - enable register 0 upper byte holds bits 13 to 8 as listed; 15 and 14 read zero.
// - enable register 0 lower byte holds bits 7 to 5 and 3 to 0; bit 4 reads zero.
// - enable register 1 upper byte holds bits 15 to 9 as listed.
// - enable register 1 holds bits 4 to 0 as listed; bits 8 to 5 read zero.
// - enable register 2 holds bits 13, 9, 7, 6, 5, 1, 0; all others read zero.
// - enable register 3 holds bits 14, 6, 5, 2, 1; all others read zero.
// - every implemented flag and enable bit is read and write and resets to zero.
// - a priority field of zero disables the source; 1 to 7 rank it, 7 highest.
`timescale 1ns/10ps
`default_nettype none
module ifb_bank (
    input  wire logic                                    clk_sys,           // system clock
    input  wire logic                                    rst_b,             // async reset
    input  wire logic [ifb_pkg::AW-1:0]                  reg_addr,          // register index
    input  wire logic [ifb_pkg::DW-1:0]                  reg_wdata,         // write data
    input  wire logic                                    reg_wr,            // write strobe
    input  wire logic                                    reg_rd,            // read strobe
    output logic      [ifb_pkg::DW-1:0]                  reg_rdata,         // read data
    input  wire logic [ifb_pkg::NEN-1:0][ifb_pkg::DW-1:0] src_flag,         // outer flag bits
    input  wire logic [ifb_pkg::NEN-1:0][ifb_pkg::DW-1:0][ifb_pkg::PW-1:0] src_prio, // levels
    input  wire logic                                    checksum_gen_evt,  // checksum event
    input  wire logic                                    serial2_error_evt, // serial 2 error
    input  wire logic                                    serial1_error_evt, // serial 1 error
    input  wire logic [ifb_pkg::NF4-1:0]                 flag4_en,          // outer enables
    input  wire logic [ifb_pkg::NF4-1:0][ifb_pkg::PW-1:0] flag4_prio,       // their levels
    output logic      [ifb_pkg::NEN-1:0][ifb_pkg::DW-1:0] irq_req,          // gated requests
    output logic      [ifb_pkg::NF4-1:0]                 flag4_req,         // gated requests
    output logic      [ifb_pkg::PW-1:0]                  irq_level,         // top pending level
    output logic                                         irq_any            // any pending
);
    localparam int unsigned NSRC = ifb_pkg::NEN * ifb_pkg::DW + ifb_pkg::NF4;

    ////////////////////////////////////////////////////////////////////////////
    // register storage

    logic [ifb_pkg::NEN-1:0][ifb_pkg::DW-1:0] en_reg;
    logic [ifb_pkg::DW-1:0]                   flag4_q;
    logic [ifb_pkg::DW-1:0]                   flag4_set;
    logic                                     flag4_wr;
    logic                                     en_wr;
    logic [1:0]                               en_idx;

    always_comb begin
        en_wr  = 1'b0;
        en_idx = 2'h0;
        if (reg_addr == ifb_pkg::OFS_EN0) begin
            en_wr  = reg_wr;
            en_idx = 2'h0;
        end else if (reg_addr == ifb_pkg::OFS_EN1) begin
            en_wr  = reg_wr;
            en_idx = 2'h1;
        end else if (reg_addr == ifb_pkg::OFS_EN2) begin
            en_wr  = reg_wr;
            en_idx = 2'h2;
        end else if (reg_addr == ifb_pkg::OFS_EN3) begin
            en_wr  = reg_wr;
            en_idx = 2'h3;
        end
    end

    assign flag4_wr = reg_wr && (reg_addr == ifb_pkg::OFS_FLAG4);

    // masking on write keeps unimplemented bits at zero for good
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            for (int unsigned i = 0; i < ifb_pkg::NEN; i++) begin
                en_reg[i] <= ifb_pkg::EN_RST;
            end
        end else if (en_wr) begin
            en_reg[en_idx] <= reg_wdata & ifb_pkg::EN_MASK[en_idx];
        end
    end

    // events set flags whatever the enables hold
    always_comb begin
        flag4_set = ifb_pkg::FLAG4_RST;
        flag4_set[ifb_pkg::CHECKSUM_GEN_FLAG_BIT]  = checksum_gen_evt;
        flag4_set[ifb_pkg::SERIAL2_ERROR_FLAG_BIT] = serial2_error_evt;
        flag4_set[ifb_pkg::SERIAL1_ERROR_FLAG_BIT] = serial1_error_evt;
    end

    ifb_flag_reg #(
        .MASK (ifb_pkg::FLAG4_MASK)
    ) u_flag4 (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .wr      (flag4_wr),
        .wdata   (reg_wdata),
        .set     (flag4_set),
        .q       (flag4_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read port

    logic [ifb_pkg::DW-1:0] rd_mux;

    always_comb begin
        rd_mux = ifb_pkg::RD_IDLE;
        if (reg_addr == ifb_pkg::OFS_EN0) begin
            rd_mux = en_reg[0];
        end else if (reg_addr == ifb_pkg::OFS_EN1) begin
            rd_mux = en_reg[1];
        end else if (reg_addr == ifb_pkg::OFS_EN2) begin
            rd_mux = en_reg[2];
        end else if (reg_addr == ifb_pkg::OFS_EN3) begin
            rd_mux = en_reg[3];
        end else if (reg_addr == ifb_pkg::OFS_FLAG4) begin
            rd_mux = flag4_q;
        end
    end

    // data stands only in the cycle after the strobe
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= ifb_pkg::RD_IDLE;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : ifb_pkg::RD_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // request gating

    logic [ifb_pkg::NEN-1:0][ifb_pkg::DW-1:0] gate_req;
    logic [ifb_pkg::NF4-1:0]                  gate_f4;

    always_comb begin
        for (int unsigned r = 0; r < ifb_pkg::NEN; r++) begin
            for (int unsigned b = 0; b < ifb_pkg::DW; b++) begin
                gate_req[r][b] = src_flag[r][b] && en_reg[r][b]
                               && ifb_pkg::prio_live(src_prio[r][b]);
            end
        end
    end

    // flag4 bits 1..3 map to request slots 0..2
    always_comb begin
        for (int unsigned k = 0; k < ifb_pkg::NF4; k++) begin
            gate_f4[k] = flag4_q[k + 1] && flag4_en[k]
                       && ifb_pkg::prio_live(flag4_prio[k]);
        end
    end

    ifb_arb_if #(.N(NSRC)) arb_bus ();

    assign arb_bus.pend = {gate_f4, gate_req};
    assign arb_bus.prio = {flag4_prio, src_prio};

    ifb_level_pick #(
        .N (NSRC)
    ) u_pick (
        .arb (arb_bus)
    );

    // one cycle of latency buys glitch-free outputs
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq_req   <= '0;
            flag4_req <= '0;
        end else begin
            irq_req   <= gate_req;
            flag4_req <= gate_f4;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            irq_level <= ifb_pkg::PRIO_OFF;
            irq_any   <= 1'b0;
        end else begin
            irq_level <= arb_bus.level;
            irq_any   <= arb_bus.any;
        end
    end
endmodule
`default_nettype wire

// ==== ifb_bank_checker.sv ====
// concurrent checks on the bank's ports
`timescale 1ns/10ps
`default_nettype none
module ifb_bank_checker (
    input wire logic                  clk_sys,           // clock
    input wire logic                  rst_b,             // reset
    input wire logic [2:0]            reg_addr,          // index
    input wire logic [15:0]           reg_wdata,         // wdata
    input wire logic                  reg_wr,            // write
    input wire logic                  reg_rd,            // read
    input wire logic [15:0]           reg_rdata,         // rdata
    input wire logic [3:0][15:0]      src_flag,          // flags
    input wire logic [3:0][15:0][2:0] src_prio,          // levels
    input wire logic                  checksum_gen_evt,  // event
    input wire logic                  serial2_error_evt, // event
    input wire logic                  serial1_error_evt, // event
    input wire logic [2:0]            flag4_en,          // enables
    input wire logic [2:0][2:0]       flag4_prio,        // levels
    input wire logic [3:0][15:0]      irq_req,           // requests
    input wire logic [2:0]            flag4_req,         // requests
    input wire logic [2:0]            irq_level,         // level
    input wire logic                  irq_any            // pending
);
    logic [3:0][15:0] en_q;   // shadow of the enable registers
    logic [3:0][15:0] live_q; // nonzero priority, last edge

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            en_q <= '0;
        end else if (reg_wr && reg_addr < 3'h4) begin
            en_q[reg_addr[1:0]] <= reg_wdata & ifb_pkg::EN_MASK[reg_addr[1:0]];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            live_q <= '0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                for (int j = 0; j < 16; j++) begin
                    live_q[i][j] <= src_prio[i][j] != 3'h0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    sequence s_rd_f4;
        reg_rd && reg_addr == ifb_pkg::OFS_FLAG4;
    endsequence
    sequence s_wr_rd;
        reg_wr && reg_addr < 3'h4 ##1 reg_rd && reg_addr == $past(reg_addr);
    endsequence

    AST_FLAG4_UNUSED: assert property ($past(reg_rd) && $past(reg_addr) == 3'h4
        |-> (reg_rdata & ~ifb_pkg::FLAG4_MASK) == 16'h0000) else $error("flag4 spare bit set");
    AST_EN_UNUSED: assert property ($past(reg_rd) && $past(reg_addr) < 3'h4
        |-> (reg_rdata & ~ifb_pkg::EN_MASK[$past(reg_addr)]) == 16'h0000)
        else $error("enable spare bit set");
    AST_GATE: assert property (irq_req == ($past(src_flag) & $past(en_q) & live_q))
        else $error("gated request wrong");
    AST_EVT_CHECKSUM: assert property (checksum_gen_evt ##1 s_rd_f4 |=> reg_rdata[3])
        else $error("checksum flag not set");
    AST_EVT_SERIAL2: assert property (serial2_error_evt ##1 s_rd_f4 |=> reg_rdata[2])
        else $error("serial 2 flag not set");
    AST_EVT_SERIAL1: assert property (serial1_error_evt ##1 s_rd_f4 |=> reg_rdata[1])
        else $error("serial 1 flag not set");
    AST_F4_GATE: assert property ((flag4_req & ~$past(flag4_en)) == 3'h0)
        else $error("flag4 request while disabled");
    AST_ANY_LEVEL: assert property (irq_any == (irq_level != 3'h0))
        else $error("any and level disagree");
    AST_ANY_REQ: assert property (irq_any == (|irq_req || |flag4_req))
        else $error("any and requests disagree");
    AST_WR_RD: assert property (s_wr_rd |=>
        reg_rdata == ($past(reg_wdata, 2) & ifb_pkg::EN_MASK[$past(reg_addr, 2)]))
        else $error("enable readback wrong");
endmodule

bind ifb_bank ifb_bank_checker u_chk (
    .clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_flag(src_flag),
    .src_prio(src_prio), .checksum_gen_evt(checksum_gen_evt),
    .serial2_error_evt(serial2_error_evt), .serial1_error_evt(serial1_error_evt),
    .flag4_en(flag4_en), .flag4_prio(flag4_prio), .irq_req(irq_req),
    .flag4_req(flag4_req), .irq_level(irq_level), .irq_any(irq_any)
);
`default_nettype wire

// ==== ifb_bank_tb_top.sv ====
// self-checking bench for the interrupt flag and enable bank
`timescale 1ns/10ps
`default_nettype none
module ifb_bank_tb_top;
    logic                  clk_sys, rst_b, reg_wr, reg_rd, run, irq_any;
    logic [2:0]            reg_addr, evt, flag4_en, flag4_req, irq_level, a;
    logic [15:0]           reg_wdata, reg_rdata, d;
    logic [3:0][15:0]      src_flag, irq_req;
    logic [3:0][15:0][2:0] src_prio;
    logic [2:0][2:0]       flag4_prio;
    logic [15:0]           sh [0:7];
    int                    n_fail, total_checks, cyc;

    ifb_src_model u_src (.clk_sys(clk_sys), .rst_b(rst_b), .run(run), .src_flag(src_flag),
        .src_prio(src_prio));
    ifb_bank u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .src_flag(src_flag), .src_prio(src_prio), .checksum_gen_evt(evt[2]),
        .serial2_error_evt(evt[1]), .serial1_error_evt(evt[0]), .flag4_en(flag4_en),
        .flag4_prio(flag4_prio), .irq_req(irq_req), .flag4_req(flag4_req),
        .irq_level(irq_level), .irq_any(irq_any));

    function automatic logic [15:0] msk(input logic [2:0] x);
        case (x)
            3'h0: msk = 16'h3fef;
            3'h1: msk = 16'hfe1f;
            3'h2: msk = 16'h22e3;
            3'h3: msk = 16'h4066;
            3'h4: msk = 16'h000e;
            default: msk = 16'h0000;
        endcase
    endfunction

    task chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // strobe stays up after the edge; rd or the caller drops it, and each write raises it again
    task wr(input logic [2:0] x, input logic [15:0] v);
        reg_addr <= x;
        reg_wdata <= v;
        reg_rd <= 1'b0;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        sh[x] = v & msk(x);
    endtask

    task rd(input logic [2:0] x, output logic [15:0] v);
        reg_addr <= x;
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
        @(posedge clk_sys);
    endtask

    task chk_all();
        for (int i = 0; i < 8; i++) begin
            rd(3'(i), d);
            chk(d, sh[i]);
        end
    endtask

    task gate(input int n);
        logic [3:0][15:0]      f;
        logic [3:0][15:0][2:0] p;
        logic [2:0]            lv;
        repeat (n) begin
            @(posedge clk_sys);
            f = src_flag;
            p = src_prio;
            lv = 3'h0;
            #1;
            for (int i = 0; i < 4; i++) begin
                for (int j = 0; j < 16; j++) begin
                    f[i][j] = f[i][j] && sh[i][j] && p[i][j] != 3'h0;
                    if (f[i][j] && p[i][j] > lv) lv = p[i][j];
                end
                chk(irq_req[i], f[i]);
            end
            chk({13'h0, irq_level}, {13'h0, lv});
            chk({15'h0, irq_any}, {15'h0, lv != 3'h0});
        end
    endtask

    task end_of_test();
        $display("checks %0d failures %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            end_of_test();
        end
    end

    initial begin
        {rst_b, reg_wr, reg_rd, run, reg_addr, evt, flag4_en} = '0;
        {reg_wdata, flag4_prio, n_fail, total_checks, cyc} = '0;
        sh = '{default: 16'h0000};
        d = $urandom(32'h38ae);
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        @(posedge clk_sys);
        chk_all();
        $display("test reset values done");
        for (int i = 0; i < 8; i++) begin
            wr(3'(i), 16'hffff);
            rd(3'(i), d);
            chk(d, msk(3'(i)));
            wr(3'(i), 16'h0000);
            rd(3'(i), d);
            chk(d, 16'h0000);
        end
        $display("test full and empty done");
        repeat (40) begin
            a = 3'($urandom);
            wr(a, 16'($urandom));
            rd(a, d);
            chk(d, sh[a]);
        end
        $display("test random access done");
        // event in the same cycle as a clearing write: the set must win
        for (int k = 0; k < 3; k++) begin
            evt <= 3'(3'h1 << k);
            wr(3'h4, 16'h0000);
            evt <= 3'h0;
            rd(3'h4, d);
            chk(d, 16'(16'h0002 << k));
        end
        sh[4] = 16'h0008;
        $display("test flag events done");
        flag4_en <= 3'h4;
        for (int p = 7; p >= 0; p--) begin
            flag4_prio[2] <= 3'(p);
            repeat (2) @(posedge clk_sys);
            #1;
            chk({13'h0, irq_level}, 16'(p));
            chk({13'h0, flag4_req}, {13'h0, (p != 0) ? 3'h4 : 3'h0});
        end
        wr(3'h4, 16'hffff);
        reg_wr <= 1'b0;
        flag4_en <= 3'h3;
        flag4_prio <= {3'h1, 3'h6, 3'h2};
        repeat (2) @(posedge clk_sys);
        #1;
        chk({13'h0, flag4_req}, 16'h0003);
        chk({13'h0, irq_level}, 16'h0006);
        @(posedge clk_sys);
        flag4_prio[2] <= 3'h5;
        flag4_en <= 3'h0;
        repeat (2) @(posedge clk_sys);
        #1 chk({12'h0, flag4_req, irq_any}, 16'h0000);
        @(posedge clk_sys);
        $display("test flag requests done");
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 4; i++) wr(3'(i), (r == 0) ? 16'($urandom) : 16'hffff);
            reg_wr <= 1'b0;
            run <= 1'b1;
            gate(150);
            run <= 1'b0;
            @(posedge clk_sys);
        end
        $display("test gating done");
        rst_b <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rst_b <= 1'b1;
        sh = '{default: 16'h0000};
        @(posedge clk_sys);
        chk_all();
        $display("test second reset done");
        end_of_test();
    end
endmodule
`default_nettype wire

// ==== ifb_flag_reg.sv ====
// one software-visible flag register that hardware events set
`timescale 1ns/10ps
`default_nettype none
module ifb_flag_reg #(
    parameter logic [ifb_pkg::DW-1:0] MASK = ifb_pkg::FLAG4_MASK
) (
    input  wire logic                   clk_sys, // system clock
    input  wire logic                   rst_b,   // async reset, low
    input  wire logic                   wr,      // software write
    input  wire logic [ifb_pkg::DW-1:0] wdata,   // software data
    input  wire logic [ifb_pkg::DW-1:0] set,     // hardware set pulses
    output logic      [ifb_pkg::DW-1:0] q        // flag state
);
    logic [ifb_pkg::DW-1:0] q_next;

    // set beats a same-cycle software clear so no event is lost
    always_comb begin
        q_next = ((wr ? wdata : q) | set) & MASK;
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            q <= ifb_pkg::FLAG4_RST;
        end else begin
            q <= q_next;
        end
    end
endmodule
`default_nettype wire

// ==== ifb_level_pick.sv ====
// finds the highest priority among pending, live requests
`timescale 1ns/10ps
`default_nettype none
module ifb_level_pick #(
    parameter int unsigned N = 67
) (
    ifb_arb_if.arb arb   // pending set in, level out
);
    logic [ifb_pkg::PW-1:0] lvl;
    logic                   hit;

    always_comb begin
        lvl = ifb_pkg::PRIO_OFF;
        hit = 1'b0;
        for (int unsigned i = 0; i < N; i++) begin
            if (arb.pend[i]) begin
                hit = 1'b1;
                if (arb.prio[i] > lvl) begin
                    lvl = arb.prio[i];
                end
            end
        end
    end

    assign arb.level = lvl;
    assign arb.any   = hit;
endmodule
`default_nettype wire

// ==== ifb_pkg.sv ====
// constants and helpers shared by the interrupt flag and enable bank
package ifb_pkg;

    localparam int unsigned DW     = 16;
    localparam int unsigned AW     = 3;
    localparam int unsigned NEN    = 4;
    localparam int unsigned PW     = 3;
    localparam int unsigned NF4    = 3;

    // register indices on the plain register port
    localparam logic [AW-1:0] OFS_EN0   = 3'h0;
    localparam logic [AW-1:0] OFS_EN1   = 3'h1;
    localparam logic [AW-1:0] OFS_EN2   = 3'h2;
    localparam logic [AW-1:0] OFS_EN3   = 3'h3;
    localparam logic [AW-1:0] OFS_FLAG4 = 3'h4;

    // reset values
    localparam logic [DW-1:0] EN_RST    = 16'h0000;
    localparam logic [DW-1:0] FLAG4_RST = 16'h0000;
    localparam logic [DW-1:0] RD_IDLE   = 16'h0000;
    localparam logic [PW-1:0] PRIO_OFF  = 3'h0;

    // fourth flag register fields
    localparam int unsigned CHECKSUM_GEN_FLAG_BIT = 3;
    localparam int unsigned SERIAL2_ERROR_FLAG_BIT = 2;
    localparam int unsigned SERIAL1_ERROR_FLAG_BIT = 1;

    // enable register 0 fields
    localparam int unsigned ADC_DONE_EN_BIT           = 13;
    localparam int unsigned SERIAL1_TX_EN_BIT         = 12;
    localparam int unsigned SERIAL1_RX_EN_BIT         = 11;
    localparam int unsigned SYNC_SERIAL1_EVENT_EN_BIT = 10;
    localparam int unsigned SYNC_SERIAL1_FAULT_EN_BIT = 9;
    localparam int unsigned TIMER_THREE_EN_BIT        = 8;
    localparam int unsigned TIMER_TWO_EN_BIT          = 7;
    localparam int unsigned COMPARE_CH2_EN_BIT        = 6;
    localparam int unsigned CAPTURE_CH2_EN_BIT        = 5;
    localparam int unsigned TIMER_ONE_EN_BIT          = 3;
    localparam int unsigned COMPARE_CH1_EN_BIT        = 2;
    localparam int unsigned CAPTURE_CH1_EN_BIT        = 1;
    localparam int unsigned EXT_PIN0_EN_BIT           = 0;

    // enable register 1 fields
    localparam int unsigned SERIAL2_TX_EN_BIT         = 15;
    localparam int unsigned SERIAL2_RX_EN_BIT         = 14;
    localparam int unsigned EXT_PIN2_EN_BIT           = 13;
    localparam int unsigned TIMER_FIVE_EN_BIT         = 12;
    localparam int unsigned TIMER_FOUR_EN_BIT         = 11;
    localparam int unsigned COMPARE_CH4_EN_BIT        = 10;
    localparam int unsigned COMPARE_CH3_EN_BIT        = 9;
    localparam int unsigned EXT_PIN1_EN_BIT           = 4;
    localparam int unsigned PIN_CHANGE_EN_BIT         = 3;
    localparam int unsigned COMPARATOR_EN_BIT         = 2;
    localparam int unsigned TWOWIRE1_MASTER_EN_BIT    = 1;
    localparam int unsigned TWOWIRE1_SLAVE_EN_BIT     = 0;

    // enable register 2 fields
    localparam int unsigned PARALLEL_PORT_EN_BIT      = 13;
    localparam int unsigned COMPARE_CH5_EN_BIT        = 9;
    localparam int unsigned CAPTURE_CH5_EN_BIT        = 7;
    localparam int unsigned CAPTURE_CH4_EN_BIT        = 6;
    localparam int unsigned CAPTURE_CH3_EN_BIT        = 5;
    localparam int unsigned SYNC_SERIAL2_EVENT_EN_BIT = 1;
    localparam int unsigned SYNC_SERIAL2_FAULT_EN_BIT = 0;

    // enable register 3 fields
    localparam int unsigned CALENDAR_CLOCK_EN_BIT     = 14;
    localparam int unsigned EXT_PIN4_EN_BIT           = 6;
    localparam int unsigned EXT_PIN3_EN_BIT           = 5;
    localparam int unsigned TWOWIRE2_MASTER_EN_BIT    = 2;
    localparam int unsigned TWOWIRE2_SLAVE_EN_BIT     = 1;

    function automatic logic [DW-1:0] bitv(input int unsigned pos);
        bitv = DW'(1) << pos;
    endfunction

    localparam logic [DW-1:0] FLAG4_MASK = bitv(CHECKSUM_GEN_FLAG_BIT)
        | bitv(SERIAL2_ERROR_FLAG_BIT) | bitv(SERIAL1_ERROR_FLAG_BIT);

    localparam logic [DW-1:0] EN0_MASK = bitv(ADC_DONE_EN_BIT) | bitv(SERIAL1_TX_EN_BIT)
        | bitv(SERIAL1_RX_EN_BIT) | bitv(SYNC_SERIAL1_EVENT_EN_BIT)
        | bitv(SYNC_SERIAL1_FAULT_EN_BIT) | bitv(TIMER_THREE_EN_BIT) | bitv(TIMER_TWO_EN_BIT)
        | bitv(COMPARE_CH2_EN_BIT) | bitv(CAPTURE_CH2_EN_BIT) | bitv(TIMER_ONE_EN_BIT)
        | bitv(COMPARE_CH1_EN_BIT) | bitv(CAPTURE_CH1_EN_BIT) | bitv(EXT_PIN0_EN_BIT);

    localparam logic [DW-1:0] EN1_MASK = bitv(SERIAL2_TX_EN_BIT) | bitv(SERIAL2_RX_EN_BIT)
        | bitv(EXT_PIN2_EN_BIT) | bitv(TIMER_FIVE_EN_BIT) | bitv(TIMER_FOUR_EN_BIT)
        | bitv(COMPARE_CH4_EN_BIT) | bitv(COMPARE_CH3_EN_BIT) | bitv(EXT_PIN1_EN_BIT)
        | bitv(PIN_CHANGE_EN_BIT) | bitv(COMPARATOR_EN_BIT) | bitv(TWOWIRE1_MASTER_EN_BIT)
        | bitv(TWOWIRE1_SLAVE_EN_BIT);

    localparam logic [DW-1:0] EN2_MASK = bitv(PARALLEL_PORT_EN_BIT) | bitv(COMPARE_CH5_EN_BIT)
        | bitv(CAPTURE_CH5_EN_BIT) | bitv(CAPTURE_CH4_EN_BIT) | bitv(CAPTURE_CH3_EN_BIT)
        | bitv(SYNC_SERIAL2_EVENT_EN_BIT) | bitv(SYNC_SERIAL2_FAULT_EN_BIT);

    localparam logic [DW-1:0] EN3_MASK = bitv(CALENDAR_CLOCK_EN_BIT) | bitv(EXT_PIN4_EN_BIT)
        | bitv(EXT_PIN3_EN_BIT) | bitv(TWOWIRE2_MASTER_EN_BIT) | bitv(TWOWIRE2_SLAVE_EN_BIT);

    localparam logic [NEN-1:0][DW-1:0] EN_MASK = {EN3_MASK, EN2_MASK, EN1_MASK, EN0_MASK};

    // a zero priority field silences the source
    function automatic logic prio_live(input logic [PW-1:0] p);
        prio_live = (p != PRIO_OFF);
    endfunction

endpackage

// ==== ifb_src_model.sv ====
// peripheral request sources that feed the outer flag levels and priorities
`timescale 1ns/10ps
`default_nettype none
module ifb_src_model (
    input  wire logic                  clk_sys,  // clock
    input  wire logic                  rst_b,    // reset
    input  wire logic                  run,      // sources active
    output logic      [3:0][15:0]      src_flag, // flag levels
    output logic      [3:0][15:0][2:0] src_prio  // priority fields
);
    // new levels each cycle: no source holds still for the bank's benefit
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            src_flag <= '0;
            src_prio <= '0;
        end else if (run) begin
            for (int i = 0; i < 4; i++) begin
                src_flag[i] <= 16'($urandom);
                for (int j = 0; j < 16; j++) begin
                    src_prio[i][j] <= 3'($urandom);
                end
            end
        end else begin
            src_flag <= '0;
            src_prio <= '0;
        end
    end
endmodule
`default_nettype wire
